// ===== vrs_unit.sv
`timescale 1ns/1ns
module vrs_unit
  import vrs_pkg::*;
(
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             reset_n,
  // Issue side.
  input  wire logic             issue_valid,
  input  wire logic [31:0]      instr_word,
  input  wire logic [VEC_W-1:0] source_a,
  input  wire logic [VEC_W-1:0] source_b,
  input  wire logic [VEC_W-1:0] select_mask,
  input  wire logic             non_ieee_flush,
  // Result side.
  output logic                  result_valid,
  output logic                  op_illegal,
  output logic [VEC_W-1:0]      destination
);

  vrs_op_t          op;
  vrs_fp_op_t       fp_op;
  logic [VEC_W-1:0] rot_b;
  logic [VEC_W-1:0] rot_h;
  logic [VEC_W-1:0] rot_w;
  logic [VEC_W-1:0] shl_b;
  logic [VEC_W-1:0] fp_res;
  logic [VEC_W-1:0] res_d;
  logic [VEC_W-1:0] dest_q;
  logic             valid_q;
  logic             illegal_q;

  // Denormals are normalised so that one path serves both estimates.
  function automatic logic [34:0] fp_norm(input logic [7:0]  ex,
                                          input logic [22:0] fr);
    logic [23:0] m;
    int          k;
    k = 0;
    if (ex != 8'h00) begin
      return {1'b1, fr, $signed({3'b000, ex}) - FP_BIAS_S};
    end
    for (int i = 0; i < 23; i++) begin
      if (fr[i]) begin
        k = 23 - i;
      end
    end
    m = {1'b0, fr} << k;
    return {m, FP_DEN_EXP_S - 11'(k)};
  endfunction : fp_norm

  // Restoring square root; exact enough that the estimate is far inside
  // the error bound, traded against a long combinational path.
  function automatic logic [23:0] fp_isqrt(input logic [47:0] v);
    logic [27:0] rem;
    logic [27:0] trial;
    logic [23:0] root;
    rem  = '0;
    root = '0;
    for (int i = 23; i >= 0; i--) begin
      rem   = {rem[25:0], v[2*i +: 2]};
      trial = {2'b00, root, 2'b01};
      if (rem >= trial) begin
        rem  = rem - trial;
        root = {root[22:0], 1'b1};
      end else begin
        root = {root[22:0], 1'b0};
      end
    end
    return root;
  endfunction : fp_isqrt

  function automatic logic [31:0] fp_recip(input logic [31:0] x,
                                           input logic        flush);
    logic                s;
    logic [7:0]          ex;
    logic [22:0]         fr;
    logic [23:0]         m;
    logic signed [10:0]  e;
    logic signed [10:0]  rexp;
    logic signed [10:0]  sh;
    logic [47:0]         q;
    logic [23:0]         dm;
    logic [31:0]         r;
    s  = x[31];
    ex = x[30:23];
    fr = x[22:0];
    {m, e} = fp_norm(ex, fr);
    q    = '0;
    rexp = '0;
    sh   = '0;
    dm   = '0;
    if (ex == FP_EXP_MAX && fr != 23'h0) begin
      r = x | FP_QNAN_BIT;
    end else if (ex == FP_EXP_MAX) begin
      r = {s, 31'h0};
    end else if (ex == 8'h00 && (fr == 23'h0 || flush)) begin
      r = {s, FP_EXP_MAX, 23'h0};
    end else begin
      q    = FP_RECIP_NUM / {24'h0, m};
      rexp = (q[24] ? FP_BIAS_S : FP_BIAS_LO_S) - e;
      if (rexp >= FP_EXP_OVF_S) begin
        r = {s, FP_EXP_MAX, 23'h0};
      end else if (rexp > 11'sh000) begin
        r = {s, rexp[7:0], q[22:0]};
      end else if (flush) begin
        r = {s, 31'h0};
      end else begin
        sh = 11'sh001 - rexp;
        dm = {1'b1, q[22:0]} >> sh[4:0];
        r  = {s, 8'h00, dm[22:0]};
      end
    end
    return r;
  endfunction : fp_recip

  function automatic logic [31:0] fp_rsqrt(input logic [31:0] x);
    logic                s;
    logic [7:0]          ex;
    logic [22:0]         fr;
    logic [23:0]         m;
    logic signed [10:0]  e;
    logic signed [10:0]  eh;
    logic signed [10:0]  rexp;
    logic [47:0]         rad;
    logic [23:0]         sq;
    logic [47:0]         q;
    logic [31:0]         r;
    s  = x[31];
    ex = x[30:23];
    fr = x[22:0];
    {m, e} = fp_norm(ex, fr);
    eh   = e >>> 1;
    rad  = e[0] ? {m, 24'h0} : {1'b0, m, 23'h0};
    sq   = '0;
    q    = '0;
    rexp = '0;
    if (ex == FP_EXP_MAX && fr != 23'h0) begin
      r = x | FP_QNAN_BIT;
    end else if (ex == 8'h00 && fr == 23'h0) begin
      r = {s, FP_EXP_MAX, 23'h0};
    end else if (s) begin
      r = FP_QNAN;
    end else if (ex == FP_EXP_MAX) begin
      r = 32'h00000000;
    end else begin
      sq   = fp_isqrt(rad);
      q    = FP_RECIP_NUM / {24'h0, sq};
      rexp = FP_BIAS_S - eh - (sq == FP_UNIT_MANT ? 11'sh000 : 11'sh001);
      r    = {1'b0, rexp[7:0], q[22:0]};
    end
    return r;
  endfunction : fp_rsqrt

  // The flush bit is not an input here, so rounding cannot depend on it.
  function automatic logic [31:0] fp_round(input logic [31:0] x,
                                           input vrs_fp_op_t  mode);
    logic        s;
    logic [7:0]  ex;
    logic [7:0]  d;
    logic [4:0]  fb;
    logic [23:0] m;
    logic [23:0] mask;
    logic [23:0] half;
    logic [23:0] frac;
    logic [24:0] sum;
    logic        inc;
    logic [31:0] r;
    s    = x[31];
    ex   = x[30:23];
    m    = {1'b1, x[22:0]};
    d    = FP_EXP_INT - ex;
    fb   = d[4:0];
    mask = (24'h000001 << fb) - 24'h000001;
    half = 24'h000001 << (fb - 5'd1);
    frac = m & mask;
    inc  = 1'b0;
    sum  = '0;
    r    = x;
    if (ex == FP_EXP_MAX) begin
      r = (x[22:0] != 23'h0) ? (x | FP_QNAN_BIT) : x;
    end else if (ex >= FP_EXP_INT || (ex == 8'h00 && x[22:0] == 23'h0)) begin
      r = x;
    end else if (ex < FP_EXP_ONE) begin
      case (mode)
        VRS_FP_FLOOR: r = s ? {1'b1, FP_ONE_MAG} : 32'h00000000;
        VRS_FP_CEIL:  r = s ? 32'h80000000 : {1'b0, FP_ONE_MAG};
        VRS_FP_NEAR: begin
          r = (ex == FP_EXP_HALF && x[22:0] != 23'h0) ?
              {s, FP_ONE_MAG} : {s, 31'h0};
        end
        default:      r = {s, 31'h0};
      endcase
    end else begin
      case (mode)
        VRS_FP_FLOOR: inc = s && frac != 24'h0;
        VRS_FP_CEIL:  inc = !s && frac != 24'h0;
        VRS_FP_NEAR:  inc = frac > half || (frac == half && m[fb]);
        default:      inc = 1'b0;
      endcase
      sum = {1'b0, m & ~mask} + (inc ? {1'b0, mask} + 25'h1 : 25'h0);
      r   = {s, ex + {7'h00, sum[24]}, sum[22:0]};
    end
    return r;
  endfunction : fp_round

  always_comb begin
    op    = VRS_OP_NONE;
    fp_op = VRS_FP_RECIP;
    if ((instr_word & OPC_VA_MASK) == OPC_SELECT) begin
      op = VRS_OP_SELECT;
    end else begin
      case (instr_word & OPC_VX_MASK)
        OPC_RECIP:     begin op = VRS_OP_FP; fp_op = VRS_FP_RECIP; end
        OPC_RSQRT:     begin op = VRS_OP_FP; fp_op = VRS_FP_RSQRT; end
        OPC_RND_FLOOR: begin op = VRS_OP_FP; fp_op = VRS_FP_FLOOR; end
        OPC_RND_NEAR:  begin op = VRS_OP_FP; fp_op = VRS_FP_NEAR; end
        OPC_RND_CEIL:  begin op = VRS_OP_FP; fp_op = VRS_FP_CEIL; end
        OPC_RND_TRUNC: begin op = VRS_OP_FP; fp_op = VRS_FP_TRUNC; end
        OPC_ROT_B:     op = VRS_OP_ROT_B;
        OPC_ROT_H:     op = VRS_OP_ROT_H;
        OPC_ROT_W:     op = VRS_OP_ROT_W;
        OPC_SHL_VEC:   op = VRS_OP_SHL_VEC;
        OPC_SHL_B:     op = VRS_OP_SHL_B;
        default:       op = VRS_OP_NONE;
      endcase
    end
  end

  // The byte element units are shared by rotate and per-byte shift; half and word units only rotate.
  for (genvar i = 0; i < VEC_W / 8; i++) begin : g_byte
    vrs_elem_if #(.W(8)) bif ();
    vrs_elem_shift #(.W(8)) u_elem (.port(bif.elem));
    assign bif.value      = source_a[8*i +: 8];
    assign bif.amount_src = source_b[8*i +: 8];
    assign rot_b[8*i +: 8] = bif.rotated;
    assign shl_b[8*i +: 8] = bif.shifted;
  end
  for (genvar i = 0; i < VEC_W / 16; i++) begin : g_half
    vrs_elem_if #(.W(16)) hif ();
    vrs_elem_shift #(.W(16)) u_elem (.port(hif.elem));
    assign hif.value        = source_a[16*i +: 16];
    assign hif.amount_src   = source_b[16*i +: 16];
    assign rot_h[16*i +: 16] = hif.rotated;
  end
  for (genvar i = 0; i < VEC_W / 32; i++) begin : g_word
    vrs_elem_if #(.W(32)) wif ();
    vrs_elem_shift #(.W(32)) u_elem (.port(wif.elem));
    assign wif.value        = source_a[32*i +: 32];
    assign wif.amount_src   = source_b[32*i +: 32];
    assign rot_w[32*i +: 32] = wif.rotated;
    always_comb begin
      case (fp_op)
        VRS_FP_RECIP: begin
          fp_res[32*i +: 32] = fp_recip(source_b[32*i +: 32], non_ieee_flush);
        end
        VRS_FP_RSQRT: fp_res[32*i +: 32] = fp_rsqrt(source_b[32*i +: 32]);
        default: begin
          fp_res[32*i +: 32] = fp_round(source_b[32*i +: 32], fp_op);
        end
      endcase
    end
  end

  // Only the low three bits steer the whole shift; uneven bytes elsewhere
  // in source B are the caller's problem and are simply ignored.
  always_comb begin
    case (op)
      VRS_OP_FP:      res_d = fp_res;
      VRS_OP_ROT_B:   res_d = rot_b;
      VRS_OP_ROT_H:   res_d = rot_h;
      VRS_OP_ROT_W:   res_d = rot_w;
      VRS_OP_SELECT:  res_d = (source_a & ~select_mask) |
                              (source_b & select_mask);
      VRS_OP_SHL_VEC: res_d = source_a << source_b[SHL_CNT_W-1:0];
      VRS_OP_SHL_B:   res_d = shl_b;
      default:        res_d = '0;
    endcase
  end

  // One registered result per issued instruction and no other state.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      valid_q   <= 1'b0;
      illegal_q <= 1'b0;
    end else begin
      valid_q   <= issue_valid;
      illegal_q <= issue_valid && op == VRS_OP_NONE;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dest_q <= '0;
    end else if (issue_valid) begin
      dest_q <= res_d;
    end
  end

  assign result_valid = valid_q;
  assign op_illegal   = illegal_q;
  assign destination  = dest_q;

endmodule : vrs_unit

// ===== vrs_pkg.sv
package vrs_pkg;

  localparam int VEC_W = 128;

  // Opcode matching: the register fields are masked off before comparing.
  localparam logic [31:0] OPC_VX_MASK   = 32'hfc0007ff;
  localparam logic [31:0] OPC_VA_MASK   = 32'hfc00003f;
  localparam logic [31:0] OPC_RECIP     = 32'h1000010a;
  localparam logic [31:0] OPC_RSQRT     = 32'h1000014a;
  localparam logic [31:0] OPC_RND_FLOOR = 32'h100002ca;
  localparam logic [31:0] OPC_RND_NEAR  = 32'h1000020a;
  localparam logic [31:0] OPC_RND_CEIL  = 32'h1000028a;
  localparam logic [31:0] OPC_RND_TRUNC = 32'h1000024a;
  localparam logic [31:0] OPC_ROT_B     = 32'h10000004;
  localparam logic [31:0] OPC_ROT_H     = 32'h10000044;
  localparam logic [31:0] OPC_ROT_W     = 32'h10000084;
  localparam logic [31:0] OPC_SELECT    = 32'h1000002a;
  localparam logic [31:0] OPC_SHL_VEC   = 32'h100001c4;
  localparam logic [31:0] OPC_SHL_B     = 32'h10000104;

  // Single-precision constants and the vector shift count width.
  localparam logic [31:0] FP_QNAN_BIT   = 32'h00400000;
  localparam logic [31:0] FP_QNAN       = 32'h7fc00000;
  localparam logic [30:0] FP_ONE_MAG    = 31'h3f800000;
  localparam logic [7:0]  FP_EXP_MAX    = 8'hff;
  localparam logic [7:0]  FP_EXP_HALF   = 8'h7e;
  localparam logic [7:0]  FP_EXP_ONE    = 8'h7f;
  localparam logic [7:0]  FP_EXP_INT    = 8'h96;
  localparam logic signed [10:0] FP_BIAS_S     = 11'sh07f;
  localparam logic signed [10:0] FP_BIAS_LO_S  = 11'sh07e;
  localparam logic signed [10:0] FP_DEN_EXP_S  = -11'sh07e;
  localparam logic signed [10:0] FP_EXP_OVF_S  = 11'sh0ff;
  localparam logic [47:0] FP_RECIP_NUM  = 48'h800000000000;
  localparam logic [23:0] FP_UNIT_MANT  = 24'h800000;
  localparam int          SHL_CNT_W     = 3;

  typedef enum logic [3:0] {
    VRS_OP_NONE, VRS_OP_FP, VRS_OP_ROT_B, VRS_OP_ROT_H, VRS_OP_ROT_W,
    VRS_OP_SELECT, VRS_OP_SHL_VEC, VRS_OP_SHL_B
  } vrs_op_t;

  typedef enum logic [2:0] {
    VRS_FP_RECIP, VRS_FP_RSQRT, VRS_FP_FLOOR, VRS_FP_NEAR, VRS_FP_CEIL,
    VRS_FP_TRUNC
  } vrs_fp_op_t;

endpackage : vrs_pkg

// ===== vrs_elem_if.sv
`timescale 1ns/1ns
interface vrs_elem_if #(
  parameter int W = 8
);
  logic [W-1:0] value;
  logic [W-1:0] amount_src;
  logic [W-1:0] rotated;
  logic [W-1:0] shifted;

  modport user (output value, output amount_src, input rotated,
                input shifted);
  modport elem (input value, input amount_src, output rotated,
                output shifted);
endinterface : vrs_elem_if

// ===== vrs_elem_shift.sv
`timescale 1ns/1ns
module vrs_elem_shift
  import vrs_pkg::*;
#(
  parameter int W = 8
) (
  // Element operands and results.
  vrs_elem_if.elem port
);

  localparam int AW = $clog2(W);

  logic [AW-1:0]  amt;
  logic [2*W-1:0] doubled;

  // Refused at elaboration: the rotate relies on a power-of-two width.
  if (W < 2 || (1 << AW) != W) begin : g_bad_width
    $error("vrs_elem_shift: W must be a power of two");
  end

  // Only the low bits of the amount element count.
  assign amt          = port.amount_src[AW-1:0];
  assign doubled      = {port.value, port.value} << amt;
  assign port.rotated = doubled[2*W-1:W];
  assign port.shifted = port.value << amt;

endmodule : vrs_elem_shift

// ===== vrs_unit_checker.sv
`timescale 1ns/1ns
module vrs_unit_checker
  import vrs_pkg::*;
(
  // Clock and reset.
  input wire logic             clk,
  input wire logic             reset_n,
  // Issue side.
  input wire logic             issue_valid,
  input wire logic [31:0]      instr_word,
  input wire logic [VEC_W-1:0] source_a,
  input wire logic [VEC_W-1:0] source_b,
  input wire logic [VEC_W-1:0] select_mask,
  input wire logic             non_ieee_flush,
  // Result side.
  input wire logic             result_valid,
  input wire logic             op_illegal,
  input wire logic [VEC_W-1:0] destination
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_vx(logic [31:0] opc);
    issue_valid && (instr_word & OPC_VX_MASK) == opc;
  endsequence
  sequence s_sel;
    issue_valid && (instr_word & OPC_VA_MASK) == OPC_SELECT;
  endsequence

  a_result_follows: assert property (
    issue_valid |=> result_valid) else $error("result missing");
  a_no_extra: assert property (
    !issue_valid |=> !result_valid && $stable(destination))
    else $error("result without issue");
  a_illegal_zero: assert property (
    op_illegal |-> result_valid && destination == 128'h0)
    else $error("illegal result not zero");
  a_select_bits: assert property (
    s_sel |=> destination == (($past(source_a) & ~$past(select_mask))
      | ($past(source_b) & $past(select_mask))))
    else $error("select wrong");
  a_shift_whole: assert property (
    s_vx(OPC_SHL_VEC) |=>
      destination == $past(source_a) << ($past(source_b) & 128'h7))
    else $error("vector shift wrong");
  a_rot_zero: assert property (
    s_vx(OPC_ROT_W) ##0 source_b == 128'h0 |=>
      destination == $past(source_a)) else $error("rotate by 0 wrong");
  a_recip_zero: assert property (
    s_vx(OPC_RECIP) ##0 source_b[31:0] == 32'h0 |=>
      destination[31:0] == 32'h7f800000) else $error("recip of 0 wrong");
  a_rsqrt_neg: assert property (
    s_vx(OPC_RSQRT) ##0 (source_b[31] && source_b[30:0] != 31'h0
      && source_b[30:23] != 8'hff) |=> destination[31:0] == FP_QNAN)
    else $error("rsqrt of negative wrong");
endmodule : vrs_unit_checker

bind vrs_unit vrs_unit_checker vrs_unit_checker_i (
  .clk(clk), .reset_n(reset_n), .issue_valid(issue_valid),
  .instr_word(instr_word), .source_a(source_a), .source_b(source_b),
  .select_mask(select_mask), .non_ieee_flush(non_ieee_flush),
  .result_valid(result_valid), .op_illegal(op_illegal),
  .destination(destination));

// ===== vrs_issue_model.sv
`timescale 1ns/1ns
module vrs_issue_model
  import vrs_pkg::*;
(
  // Clock in.
  input  wire logic        clk,
  // Issue out.
  output logic             issue_valid,
  output logic [31:0]      instr_word,
  output logic [VEC_W-1:0] source_a,
  output logic [VEC_W-1:0] source_b,
  output logic [VEC_W-1:0] select_mask,
  output logic             non_ieee_flush
);
  initial begin
    issue_valid = 1'b0;
    instr_word = 32'h0;
    source_a = 128'h0;
    source_b = 128'h0;
    select_mask = 128'h0;
    non_ieee_flush = 1'b0;
  end

  // Register fields are set so the opcode decode must mask them off.
  task automatic issue(input logic [31:0] op,
                       input logic [VEC_W-1:0] a, b, c, input logic f);
    logic [VEC_W-1:0] bb;
    bb = b;
    if (op == OPC_SHL_VEC) begin
      for (int k = 8; k < VEC_W; k += 8) begin
        bb[k +: 3] = b[2:0];
      end
    end
    @(posedge clk);
    issue_valid <= 1'b1;
    instr_word <= op | 32'h00210800;
    source_a <= a;
    source_b <= bb;
    select_mask <= c;
    non_ieee_flush <= f;
    @(posedge clk);
    // Idle sources are inverted so a stale value is never mistaken for live.
    issue_valid <= 1'b0;
    instr_word <= ~op;
    source_a <= ~a;
    source_b <= ~bb;
    select_mask <= ~c;
  endtask : issue
endmodule : vrs_issue_model

// ===== vrs_unit_tb.sv
`timescale 1ns/1ns
module vrs_unit_tb
  import vrs_pkg::*;
;
  localparam logic [VEC_W-1:0] PA = 128'h0123456789abcdeffedcba9876543210;
  localparam logic [VEC_W-1:0] PB = 128'h0706050403020100f1e2d3c4b5a69788;
  localparam logic [VEC_W-1:0] PC = 128'hff00f0f0cccc5555a5a5000012345678;
  logic             clk = 1'b0;
  logic             reset_n = 1'b0;
  logic             issue_valid;
  logic [31:0]      instr_word;
  logic [VEC_W-1:0] source_a;
  logic [VEC_W-1:0] source_b;
  logic [VEC_W-1:0] select_mask;
  logic             non_ieee_flush;
  logic             result_valid;
  logic             op_illegal;
  logic [VEC_W-1:0] destination;
  int               n_errors = 0;
  int               cmp_count = 0;
  int               cycles = 0;

  always #4 clk = ~clk;

  vrs_issue_model vrs_issue_model_i (.clk(clk), .issue_valid(issue_valid),
    .instr_word(instr_word), .source_a(source_a), .source_b(source_b),
    .select_mask(select_mask), .non_ieee_flush(non_ieee_flush));
  vrs_unit vrs_unit_i (.clk(clk), .reset_n(reset_n),
    .issue_valid(issue_valid), .instr_word(instr_word),
    .source_a(source_a), .source_b(source_b), .select_mask(select_mask),
    .non_ieee_flush(non_ieee_flush), .result_valid(result_valid),
    .op_illegal(op_illegal), .destination(destination));

  task automatic summarize();
    $display("errors %0d, compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string what, input logic [VEC_W-1:0] e, g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", what, e, g);
    end
  endtask : chk

  task automatic chk_flag(input string what, input logic [1:0] e, g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s exp %b got %b", what, e, g);
    end
  endtask : chk_flag

  // Result lands at the taking edge; look one step later.
  task automatic run(input string what, input logic [31:0] op,
                     input logic [VEC_W-1:0] a, b, c, input logic f,
                     input logic [VEC_W-1:0] e, input logic ill);
    vrs_issue_model_i.issue(op, a, b, c, f);
    #1;
    chk_flag({what, " flags"}, {1'b1, ill}, {result_valid, op_illegal});
    chk(what, e, destination);
  endtask : run

  function automatic logic [VEC_W-1:0] elem_op(
      input logic [VEC_W-1:0] a, b, input int w, input bit rot);
    logic [VEC_W-1:0] r;
    int               s;
    r = 128'h0;
    for (int k = 0; k < VEC_W; k += w) begin
      s = b[k +: 5] & (w - 1);
      for (int i = 0; i < w; i++) begin
        if (rot || i + s < w) r[k + (i + s) % w] = a[k + i];
      end
    end
    return r;
  endfunction : elem_op

  task automatic t_elem();
    run("rot b", OPC_ROT_B, PA, PB, PC, 0, elem_op(PA, PB, 8, 1), 0);
    run("rot h", OPC_ROT_H, PA, PB, PC, 0, elem_op(PA, PB, 16, 1), 0);
    run("rot w", OPC_ROT_W, PA, PB, PC, 0, elem_op(PA, PB, 32, 1), 0);
    run("rot w 0", OPC_ROT_W, PA, 128'h0, PC, 0, PA, 0);
    run("shl b", OPC_SHL_B, PA, PB, PC, 0, elem_op(PA, PB, 8, 0), 0);
  endtask : t_elem

  task automatic t_vector();
    run("sel", OPC_SELECT, PA, PB, PC, 0, (PA & ~PC) | (PB & PC), 0);
    for (int s = 0; s < 8; s++) begin
      run("shl v", OPC_SHL_VEC, PA, PB & ~128'h7 | s, PC, 0, PA << s, 0);
    end
    run("unknown", 32'h10000400, PA, PB, PC, 0, 128'h0, 1);
  endtask : t_vector

  task automatic t_round();
    logic [VEC_W-1:0] b;
    b = {32'hbf000000, 32'h3fe00000, 32'hc0200000, 32'h40200000};
    for (int f = 0; f < 2; f++) begin
      run("floor", OPC_RND_FLOOR, PA, b, PC, f[0], {32'hbf800000,
        32'h3f800000, 32'hc0400000, 32'h40000000}, 0);
      run("near", OPC_RND_NEAR, PA, b, PC, f[0], {32'h80000000,
        32'h40000000, 32'hc0000000, 32'h40000000}, 0);
      run("ceil", OPC_RND_CEIL, PA, b, PC, f[0], {32'h80000000,
        32'h40000000, 32'hc0000000, 32'h40400000}, 0);
      run("trunc", OPC_RND_TRUNC, PA, b, PC, f[0], {32'h80000000,
        32'h3f800000, 32'hc0000000, 32'h40000000}, 0);
    end
  endtask : t_round

  task automatic t_fp_est();
    run("rcp sp", OPC_RECIP, PA, {32'h7f800000, 32'hff800000, 32'h80000000,
      32'h0}, PC, 0, {32'h0, 32'h80000000, 32'hff800000,
      32'h7f800000}, 0);
    run("rcp fz", OPC_RECIP, PA, {32'h7f000000, 32'h1, 32'h40000000,
      32'h7f800001}, PC, 1, {32'h0, 32'h7f800000, 32'h3f000000,
      32'h7fc00001}, 0);
    run("rcp dn", OPC_RECIP, PA, {32'h7f000000, 32'h40800000,
      32'h3f800000, 32'hc0000000}, PC, 0, {32'h00400000, 32'h3e800000,
      32'h3f800000, 32'hbf000000}, 0);
    run("rsq sp", OPC_RSQRT, PA, {32'h0, 32'h80000000, 32'hff800000,
      32'hbf800000}, PC, 0, {32'h7f800000, 32'hff800000, FP_QNAN,
      FP_QNAN}, 0);
    run("rsq v", OPC_RSQRT, PA, {32'h7fc00000, 32'h3f800000,
      32'h40800000, 32'h7f800000}, PC, 1, {32'h7fc00000, 32'h3f800000,
      32'h3f000000, 32'h0}, 0);
  endtask : t_fp_est

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_errors++;
      summarize();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    chk_flag("reset flags", 2'b00, {result_valid, op_illegal});
    chk("reset dest", 128'h0, destination);
    t_elem();
    t_vector();
    t_round();
    t_fp_est();
    summarize();
  end
endmodule : vrs_unit_tb
